/* File: pkg/low_power_clock_pkg.sv */
// Constants and types shared by the low-power clock controller
package low_power_clock_pkg;
    // ********************************
    // Clock and time base
    // ********************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int SPIKE_MIN_NS = 100; // Least spacing of real main edges
    localparam int MAIN_MISS_NS = 1000; // Longest gap before an edge counts as missing
    localparam int AUX_PERIOD_NS = 2000; // Period of the auxiliary oscillator
    localparam logic [7:0] SPIKE_MIN_CYC = 8'((SPIKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] MAIN_MISS_CYC = 8'((MAIN_MISS_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [7:0] AUX_CYC = 8'((AUX_PERIOD_NS * 1000) / CLK_PERIOD_PS);
    // ********************************
    // Counts in internal clock ticks and machine cycles
    // ********************************
    localparam logic [3:0] PERIPH_DIV = 4'hc; // Peripheral clock divider
    localparam int RST_DELAY_TICKS = 2048; // Internal reset delay
    localparam logic [2:0] MC_SHORT = 3'h2;
    localparam logic [2:0] MC_MID = 3'h4;
    localparam logic [2:0] MC_LONG = 3'h5;
    // ********************************
    // Register map
    // ********************************
    localparam logic [11:0] ADDR_CTRL = 12'h000; // Oscillator control
    localparam logic [11:0] ADDR_STAT = 12'h004; // Block status
    localparam int CTRL_MAIN_OSC_OFF_BIT_BIT = 0;
    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {PW_RUN, PW_WAIT, PW_STOP, PW_STAB} pwr_t;
    typedef enum logic [1:0] {MODE_MAIN, MODE_NMI, MODE_INT} mode_t;
    typedef enum logic [1:0] {ACT_NONE, ACT_RESUME, ACT_ISR, ACT_NMI_FIRST} wake_act_t;
    typedef struct packed {
        pwr_t pst;
        mode_t entryMode;
        wake_act_t wakeAct;
        logic optCaught, optRc, optSafe, main_osc_off_bit, mainOscEn, halt;
        logic coreRst, wakeNmi, mainPrev, mainRun, auxRun, intTick, periphTick;
        logic instrBusy, instrDone, wakePulse, lpSkip, pready, pslverr;
        logic [11:0] rstCnt, stabCnt;
        logic [7:0] gapCnt, auxCnt;
        logic [3:0] divCnt;
        logic [2:0] instrCnt;
        logic [31:0] prdata;
    } ctl_t;
    localparam ctl_t CTL_RST = '{pst: PW_RUN, entryMode: MODE_MAIN, wakeAct: ACT_NONE,
        coreRst: 1'b1, halt: 1'b1, mainOscEn: 1'b1, default: '0};
endpackage

/* File: hw/low_power_clock_control.sv */
// Power-mode and clock-source controller for a small 8-bit core
`timescale 1ns/1ps
`default_nettype none
// ********************************
// ********************************
module low_power_clock_control
    import low_power_clock_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic optRcNetwork,
    input wire logic optSafeguard,
    input wire logic mainOscIn,
    input wire logic wdogActive,
    input wire logic wdogRst,
    input wire logic lpReq,
    input wire logic lpStop,
    input wire logic [1:0] coreMode,
    input wire logic irqReq,
    input wire logic nmiReq,
    input wire logic globalIntEnable,
    input wire logic instrStart,
    input wire logic [1:0] instrLen,
    output logic coreRst,
    output logic coreHalt,
    output logic mainOscEnable,
    output logic auxOscRun,
    output logic intTick,
    output logic periphTick,
    output logic instrDone,
    output logic wakePulse,
    output logic [1:0] wakeAction,
    output logic lpSkipped,
    output logic [1:0] powerState
);
    // ********************************
    // State and helper signals
    // ********************************
    ctl_t r; // Registered state
    ctl_t n; // Next state
    logic mainEdge; // Raw rising edge of main oscillator
    logic edgeOk; // Edge that passed the spike filter
    logic auxTick; // One auxiliary oscillator period
    logic tick; // Internal clock tick
    logic nmiOk; // NMI allowed by the global enable
    logic wake; // Any enabled wake-up source
    logic acc; // APB access phase
    logic [31:0] rdVal; // Read mux

    // Decide what the core does after wake-up
    function automatic wake_act_t pickAct(input mode_t m, input logic nmi);
        wake_act_t a;
        a = ACT_RESUME;
        case (m)
            MODE_MAIN: a = ACT_ISR;
            MODE_NMI: a = ACT_RESUME;
            MODE_INT: a = nmi ? ACT_NMI_FIRST : ACT_RESUME;
            default: a = ACT_RESUME;
        endcase
        return a;
    endfunction

    // Cycle count of an instruction class
    function automatic logic [2:0] lenCycles(input logic [1:0] c);
        logic [2:0] v;
        v = MC_SHORT;
        case (c)
            2'h1: v = MC_MID;
            2'h2: v = MC_LONG;
            default: v = MC_SHORT;
        endcase
        return v;
    endfunction

    // ********************************
    // Next-state logic
    // ********************************
    always_comb begin
        n = r;
        n.lpSkip = 1'b0;
        n.wakePulse = 1'b0;
        n.instrDone = 1'b0;
        n.periphTick = 1'b0;
        // Options caught once after reset and then frozen
        if (!r.optCaught) begin
            n.optCaught = 1'b1;
            n.optSafe = optSafeguard;
            n.optRc = optRcNetwork;
        end
        // Main oscillator edge, filtered when safeguard is on
        mainEdge = mainOscIn & ~r.mainPrev;
        n.mainPrev = mainOscIn;
        // Counter reads one less than the cycles since the last edge, so compare against min - 1
        edgeOk = mainEdge & (~r.optSafe | (r.gapCnt >= SPIKE_MIN_CYC - 8'h01));
        if (edgeOk) begin
            n.gapCnt = 8'h00;
            n.mainRun = 1'b1;
        end else begin
            // Saturate so a dead oscillator never wraps back to running
            if (r.gapCnt != 8'hff) begin
                n.gapCnt = r.gapCnt + 8'h01;
            end
            if (r.gapCnt >= MAIN_MISS_CYC) begin
                n.mainRun = 1'b0;
            end
        end
        // First auxiliary tick comes a full period after start
        auxTick = r.auxRun & (r.auxCnt == AUX_CYC - 8'h01);
        if (!r.auxRun || auxTick) begin
            n.auxCnt = 8'h00;
        end else begin
            n.auxCnt = r.auxCnt + 8'h01;
        end
        // Internal clock from whichever source runs
        tick = (edgeOk & r.mainRun) | auxTick;
        n.intTick = tick;
        // Peripheral clock divider
        if (tick) begin
            if (r.divCnt == PERIPH_DIV - 4'h1) begin
                n.divCnt = 4'h0;
                n.periphTick = 1'b1;
            end else begin
                n.divCnt = r.divCnt + 4'h1;
            end
        end
        // Instruction timing in machine cycles
        if (r.instrBusy && r.periphTick) begin
            if (r.instrCnt == 3'h1) begin
                n.instrBusy = 1'b0;
                n.instrDone = 1'b1;
            end else begin
                n.instrCnt = r.instrCnt - 3'h1;
            end
        end else if (instrStart && !r.instrBusy && !r.halt) begin
            n.instrBusy = 1'b1;
            n.instrCnt = lenCycles(instrLen);
        end
        // Reset delay counts internal ticks, whatever the source
        if (r.coreRst && tick) begin
            if (r.rstCnt == 12'(RST_DELAY_TICKS - 1)) begin
                n.coreRst = 1'b0;
            end else begin
                n.rstCnt = r.rstCnt + 12'h001;
            end
        end
        // Wake sources; NMI needs the global enable
        nmiOk = nmiReq & globalIntEnable;
        wake = irqReq | nmiOk;
        // Power state machine
        case (r.pst)
            PW_RUN: begin
                if (lpReq && !r.coreRst) begin
                    if (wake) begin
                        n.lpSkip = 1'b1;
                    end else begin
                        n.entryMode = mode_t'(coreMode);
                        // Stop is refused while any watchdog runs
                        n.pst = (lpStop && !wdogActive) ? PW_STOP : PW_WAIT;
                    end
                end
            end
            PW_WAIT: begin
                // Clock kept running, so resume at once
                if (wake) begin
                    n.pst = PW_RUN;
                    n.wakePulse = 1'b1;
                    n.wakeAct = pickAct(r.entryMode, nmiOk); // Off bit left alone
                end
            end
            PW_STOP: begin
                if (wake) begin
                    n.pst = PW_STAB;
                    n.stabCnt = 12'h000;
                    n.wakeNmi = nmiOk;
                end
            end
            PW_STAB: begin
                // Oscillator restarting; hold the core until settled
                if (tick) begin
                    if (r.stabCnt == 12'(RST_DELAY_TICKS - 1)) begin
                        n.pst = PW_RUN;
                        n.wakePulse = 1'b1;
                        n.wakeAct = pickAct(r.entryMode, r.wakeNmi);
                    end else begin
                        n.stabCnt = r.stabCnt + 12'h001;
                    end
                end
            end
            default: begin
                n.pst = PW_RUN;
            end
        endcase
        // APB slave: two-cycle access, answer in second cycle
        acc = psel & penable;
        n.pready = acc & ~r.pready;
        n.pslverr = 1'b0;
        rdVal = 32'h0000_0000;
        if (paddr == ADDR_CTRL) begin
            rdVal[CTRL_MAIN_OSC_OFF_BIT_BIT] = r.main_osc_off_bit;
        end else if (paddr == ADDR_STAT) begin
            rdVal[1:0] = r.pst;
            rdVal[2] = r.mainRun;
            rdVal[3] = r.auxRun;
            rdVal[4] = r.coreRst;
            rdVal[5] = r.optSafe;
            rdVal[6] = r.optRc;
            rdVal[7] = r.mainOscEn;
        end else begin
            n.pslverr = acc & ~r.pready;
        end
        if (acc && !r.pready) begin
            n.prdata = pwrite ? 32'h0000_0000 : rdVal;
        end
        // Writes land on the edge where pready is seen high
        if (acc && r.pready && pwrite && (paddr == ADDR_CTRL) && pstrb[0]) begin
            n.main_osc_off_bit = pwdata[CTRL_MAIN_OSC_OFF_BIT_BIT];
        end
        // Watchdog reset wins over the power state, reset count, off bit and instruction timer, incl. a bus write
        if (wdogRst) begin
            n.coreRst = 1'b1;
            n.rstCnt = 12'h000;
            n.main_osc_off_bit = 1'b0;
            n.pst = PW_RUN;
            n.instrBusy = 1'b0;
        end
        // Auxiliary runs only with safeguard and no main clock; next state so stop halts it at once
        n.auxRun = r.optSafe & ~r.mainRun & (n.pst != PW_STOP);
        // Off bit only matters with safeguard, which brings the backup clock
        n.mainOscEn = ~(n.main_osc_off_bit & r.optSafe) & (n.pst != PW_STOP);
        n.halt = n.coreRst | (n.pst != PW_RUN);
    end

    // ********************************
    // State register
    // ********************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= CTL_RST;
        end else begin
            r <= n;
        end
    end

    // ********************************
    // Outputs, all from flops
    // ********************************
    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign coreRst = r.coreRst;
    assign coreHalt = r.halt;
    assign mainOscEnable = r.mainOscEn;
    assign auxOscRun = r.auxRun;
    assign intTick = r.intTick;
    assign periphTick = r.periphTick;
    assign instrDone = r.instrDone;
    assign wakePulse = r.wakePulse;
    assign wakeAction = r.wakeAct;
    assign lpSkipped = r.lpSkip;
    assign powerState = r.pst;

    // ********************************
    // Checks
    // ********************************
    logic [3:0] tickSeen; // Internal ticks since last peripheral tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tickSeen <= 4'h0;
        end else if (r.periphTick) begin
            tickSeen <= 4'h0;
        end else if (r.intTick) begin
            tickSeen <= tickSeen + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    skipPending_a: assert property ((r.pst == PW_RUN) && lpReq && !r.coreRst && wake && !wdogRst
        |=> r.lpSkip && (r.pst == PW_RUN))
        else $error("low-power entry not skipped");
    stopAsWait_a: assert property ((r.pst == PW_RUN) && lpReq && lpStop && wdogActive && !wake
        && !r.coreRst && !wdogRst |=> r.pst == PW_WAIT)
        else $error("stop entered with watchdog on");
    waitWake_a: assert property ((r.pst == PW_WAIT) && wake && !wdogRst
        |=> (r.pst == PW_RUN) && r.wakePulse)
        else $error("wait exit delayed");
    stopSettle_a: assert property (r.wakePulse |-> $past(r.pst) != PW_STOP)
        else $error("stop exit without stabilization");
    stopOscOff_a: assert property ((r.pst == PW_STOP) |-> !r.mainOscEn && !r.auxRun)
        else $error("oscillator running in stop");
    wakeKeepsOsc_a: assert property (r.wakePulse && !$past(pready) |-> $stable(r.main_osc_off_bit))
        else $error("wake changed oscillator choice");
    nmiResume_a: assert property (r.wakePulse && (r.entryMode == MODE_NMI)
        |-> r.wakeAct == ACT_RESUME)
        else $error("wrong action from NMI routine");
    intNmiFirst_a: assert property ((r.pst == PW_WAIT) && (r.entryMode == MODE_INT) && nmiOk
        && !wdogRst |=> r.wakeAct == ACT_NMI_FIRST)
        else $error("NMI not served first");
    deadWait_a: assert property ((r.pst == PW_WAIT) && !irqReq && !(nmiReq && globalIntEnable)
        && !wdogRst |=> r.pst == PW_WAIT)
        else $error("wake without enabled source");
    divTwelve_a: assert property (r.periphTick |-> tickSeen == 4'hb)
        else $error("peripheral tick not at twelve");
    auxOff_a: assert property (r.mainRun |=> !r.auxRun)
        else $error("auxiliary left running");
    auxSafe_a: assert property (r.auxRun |-> r.optSafe)
        else $error("auxiliary without safeguard");
    wdogFull_a: assert property (wdogRst |=> r.coreRst && (r.pst == PW_RUN) && !r.main_osc_off_bit)
        else $error("watchdog reset incomplete");
    rstRelease_a: assert property ($fell(r.coreRst) |-> $past(r.rstCnt) == 12'(RST_DELAY_TICKS - 1))
        else $error("internal reset released early");

    enterStop_c: cover property ((r.pst == PW_STOP) ##1 (r.pst == PW_STAB));
    waitWake_c: cover property ((r.pst == PW_WAIT) ##1 r.wakePulse);
    skip_c: cover property (r.lpSkip);
    auxClock_c: cover property (r.auxRun && r.intTick);
endmodule
`default_nettype wire

/* File: test/osc_model.sv */
// Main oscillator model that runs only while the controller enables it
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    output logic oscOut
);
    logic [1:0] phase; // Position within one four-clock period
    // One rising edge every four clocks, the closest spacing that the spike filter still passes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 2'h0;
            oscOut <= 1'b0;
        end else if (!enable) begin
            // A stopped oscillator leaves its line low, so every edge goes missing
            phase <= 2'h0;
            oscOut <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            oscOut <= phase[1];
        end
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the low-power clock controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import low_power_clock_pkg::*;
    // ********************************
    // Stimulus, core side and bus
    // ********************************
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic wdogActive = 1'b0, wdogRst = 1'b0, lpReq = 1'b0, lpStop = 1'b0, irqReq = 1'b0;
    logic nmiReq = 1'b0, globalIntEnable = 1'b1, instrStart = 1'b0, err, mainOscIn;
    logic [1:0] coreMode = 2'h0, instrLen = 2'h0;
    logic pready, pslverr, coreRst, coreHalt, mainOscEnable, auxOscRun, intTick, periphTick;
    logic instrDone, wakePulse, lpSkipped;
    logic [31:0] prdata;
    logic [1:0] wakeAction, powerState;
    logic rstPrev = 1'b0; // Core reset as seen at the previous edge
    int n_mismatch = 0, num_checks = 0, rstTicks = 0, i, k, cnt;
    int modeTab[4] = '{0, 1, 2, 2}; // Routine the core was in
    int nmiTab[4] = '{0, 0, 0, 1}; // Wake source: 1 means non-maskable
    int actTab[4] = '{2, 1, 1, 3}; // Expected wake action
    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;
    osc_model osc (.clk(clk), .arst_n(arst_n), .enable(mainOscEnable), .oscOut(mainOscIn));
    low_power_clock_control DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .optRcNetwork(1'b1), .optSafeguard(1'b1),
        .mainOscIn(mainOscIn), .wdogActive(wdogActive), .wdogRst(wdogRst), .lpReq(lpReq),
        .lpStop(lpStop), .coreMode(coreMode), .irqReq(irqReq), .nmiReq(nmiReq),
        .globalIntEnable(globalIntEnable), .instrStart(instrStart), .instrLen(instrLen),
        .coreRst(coreRst), .coreHalt(coreHalt), .mainOscEnable(mainOscEnable),
        .auxOscRun(auxOscRun), .intTick(intTick), .periphTick(periphTick),
        .instrDone(instrDone), .wakePulse(wakePulse), .wakeAction(wakeAction),
        .lpSkipped(lpSkipped), .powerState(powerState));
    // Counts ticks that advance the reset delay; intTick lags its tick by one cycle
    always @(posedge clk) begin
        rstPrev <= coreRst;
        if (wdogRst) begin
            rstTicks <= 0;
        end else if (arst_n && rstPrev === 1'b1 && intTick === 1'b1) begin
            rstTicks <= rstTicks + 1;
        end
    end
    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One APB transfer; entered right after a rising edge, holds everything until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        // No wait-state count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Core executes one wait or stop; returns when the resulting state is visible
    task automatic lowPower(input logic stop, input logic [1:0] mode);
        lpReq <= 1'b1;
        lpStop <= stop;
        coreMode <= mode;
        @(posedge clk) lpReq <= 1'b0;
        @(posedge clk);
    endtask
    // Raises a wake source and checks the wake report within a bound
    task automatic wake(input logic nmi, input logic [1:0] act, input int bound);
        if (nmi) nmiReq <= 1'b1;
        else irqReq <= 1'b1;
        for (k = 0; k < bound && wakePulse !== 1'b1; k++) @(posedge clk);
        check(wakePulse, 32'h1);
        check(wakeAction, act);
        check(powerState, 32'h0);
        irqReq <= 1'b0;
        nmiReq <= 1'b0;
        @(posedge clk);
    endtask
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 20000 && coreRst !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        check(rstTicks, RST_DELAY_TICKS);
        // Status: run, main running, no aux, both options caught at reset
        apb(1'b0, ADDR_STAT, 32'h0);
        check(rd[7:0], 8'he4);
        apb(1'b0, 12'h100, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        // Twelve internal ticks between peripheral ticks, counted inclusively
        for (i = 0; i < 500 && periphTick !== 1'b1; i++) @(posedge clk);
        cnt = 0;
        do begin
            @(posedge clk);
            cnt += intTick;
        end while (periphTick !== 1'b1 && cnt < 40);
        check(cnt, 32'd12);
        // Each instruction length, in machine cycles
        for (i = 0; i < 3; i++) begin
            instrStart <= 1'b1;
            instrLen <= i[1:0];
            @(posedge clk) instrStart <= 1'b0;
            cnt = 0;
            for (k = 0; k < 2000 && instrDone !== 1'b1; k++) begin
                @(posedge clk);
                cnt += periphTick;
            end
            check(cnt, i == 0 ? MC_SHORT : i == 1 ? MC_MID : MC_LONG);
            @(posedge clk);
        end
        // Pending interrupt makes the request a no-op
        irqReq <= 1'b1;
        lowPower(1'b0, 2'h0);
        check({lpSkipped, powerState}, 32'h4);
        irqReq <= 1'b0;
        @(posedge clk);
        // Wake action for every prior routine and source
        for (i = 0; i < 4; i++) begin
            lowPower(1'b0, modeTab[i][1:0]);
            check({coreHalt, powerState}, 32'h5);
            wake(nmiTab[i][0], actTab[i][1:0], 4);
        end
        // Watchdog running turns stop into wait
        wdogActive <= 1'b1;
        lowPower(1'b1, 2'h0);
        check(powerState, 32'h1);
        wake(1'b0, 2'h2, 4);
        wdogActive <= 1'b0;
        // Stop halts the oscillator; wake goes through stabilization
        lowPower(1'b1, 2'h0);
        check({mainOscEnable, powerState}, 32'h2);
        irqReq <= 1'b1;
        repeat (3) @(posedge clk);
        check(powerState, 32'h3);
        wake(1'b0, 2'h2, 20000);
        // Off bit: main stops, auxiliary takes over and survives a wait
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h1);
        for (i = 0; i < 400 && auxOscRun !== 1'b1; i++) @(posedge clk);
        check({mainOscEnable, auxOscRun}, 32'h1);
        lowPower(1'b0, 2'h0);
        wake(1'b0, 2'h2, 400);
        check(mainOscEnable, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        for (i = 0; i < 400 && auxOscRun !== 1'b0; i++) @(posedge clk);
        check({mainOscEnable, auxOscRun}, 32'h2);
        // NMI gated off by the global enable, no interrupt raised: only the watchdog reset ends the wait
        globalIntEnable <= 1'b0;
        lowPower(1'b0, 2'h0);
        nmiReq <= 1'b1;
        repeat (20) @(posedge clk);
        check(powerState, 32'h1);
        nmiReq <= 1'b0;
        wdogRst <= 1'b1;
        @(posedge clk) wdogRst <= 1'b0;
        repeat (2) @(posedge clk);
        check(coreRst, 32'h1);
        for (i = 0; i < 20000 && coreRst !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        check({coreRst, powerState}, 32'h0);
        check(rstTicks, RST_DELAY_TICKS);
        results();
    end
    // Cuts a hang short well beyond the expected run of about 25000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
